//--- bir_far_end.sv
// far side of the message bus: pulled-up lines and a frame catcher
// assumes the design only pulls lines low and changes on rising apic_clk
module bir_far_end (
	input wire logic apic_clk,
	input wire logic reset_n,
	input wire logic [1:0] d_oe,
	input wire logic hold,
	output logic [1:0] d_in,
	output logic [13:0] last_msg,
	output int frames
);
	timeunit 1ns;
	timeprecision 100ps;
	int cnt;
	logic [13:0] sh;
	assign d_in = ~d_oe & {2{~hold}};
	// sampled mid-cycle so the design's edge has settled
	always @(negedge apic_clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt = -1;
			frames = 0;
			last_msg = 14'h0;
		end else if (cnt < 0) begin
			if (d_oe == 2'h3)
				cnt = 0;
		end else begin
			sh = {sh[11:0], ~d_oe};
			cnt++;
			if (cnt == 7) begin
				last_msg = sh;
				frames++;
				cnt = -1;
			end
		end
	end
endmodule : bir_far_end

//--- bir_params.svh
// constants for the board interrupt routing block
// assumes inclusion by bare name from the package and top-level design files
`ifndef BIR_PARAMS_SVH
`define BIR_PARAMS_SVH

`define BIR_NUM_IN 24
`define BIR_NUM_LEGACY 16
`define BIR_NUM_PCI 4
`define BIR_PCI_BASE 16
`define BIR_CASC_LVL 3'h2
`define BIR_VEC_W 8
`define BIR_IDX_W 5
`define BIR_MSG_W 14
`define BIR_MSG_CYC 3'h6
`define BIR_OE_IDLE 2'h0
`define BIR_OE_START 2'h3
`define BIR_PIN_W 27
`define BIR_ERR_W 3

`endif

//--- bir_pic.sv
// one eight-level pc-style interrupt controller
// assumes synchronous request levels and one-cycle ack and eoi pulses
module bir_pic (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] req,
	input wire logic [7:0] edge_mode,
	input wire logic [7:0] mask,
	input wire logic ack,
	input wire logic eoi,
	input wire logic [2:0] eoi_lvl,
	output logic int_o,
	output logic [2:0] sel
);
	bir_pkg::bir_pic_t st_q, st_d;
	logic [7:0] cand;
	logic [7:0] set_v;
	logic [7:0] ack_oh;
	logic [7:0] eoi_oh;
	logic found;
	logic blocked;

	always_comb begin
		st_d = st_q;
		st_d.prev = req;
		set_v = (edge_mode & req & ~st_q.prev) | (~edge_mode & req);
		cand = st_q.irr & ~mask;
		sel = 3'h0;
		found = 1'b0;
		blocked = 1'b0;
		// lowest level wins; in-service levels block their own and all higher-numbered levels
		for (int i = 0; i < 8; i++) begin
			if (!found && !blocked && st_q.isr[i]) begin
				blocked = 1'b1;
			end
			if (!found && !blocked && cand[i]) begin
				found = 1'b1;
				sel = 3'(i);
			end
		end
		int_o = found;
		ack_oh = (ack && found) ? (8'h01 << sel) : 8'h00;
		eoi_oh = eoi ? (8'h01 << eoi_lvl) : 8'h00;
		// a fresh request beats the clear of the same cycle
		st_d.irr = ((st_q.irr & ~ack_oh) & (edge_mode | req)) | set_v;
		st_d.isr = (st_q.isr & ~eoi_oh) | ack_oh;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end
endmodule : bir_pic

//--- bir_pkg.sv
// types shared by the board interrupt routing design
// assumes bir_params.svh is compiled alongside
`include "bir_params.svh"
package bir_pkg;

	typedef enum logic [2:0] {
		BIR_L_IDLE,
		BIR_L_WAIT,
		BIR_L_START,
		BIR_L_DATA,
		BIR_L_END
	} bir_lstate_t;

	typedef struct packed {
		logic [7:0] irr;
		logic [7:0] isr;
		logic [7:0] prev;
	} bir_pic_t;

	typedef struct packed {
		logic [23:0] pend;
		logic [23:0] rirr;
		logic [23:0] prev;
		logic req_tgl;
		logic [13:0] msg;
		logic cpu_irq;
		logic smi_n;
		logic ack_valid;
		logic [3:0] ack_level;
		logic [1:0] ack_owner;
	} bir_sys_t;

	typedef struct packed {
		bir_lstate_t st;
		logic [2:0] cnt;
		logic seen;
		logic ack_tgl;
		logic [13:0] sh;
		logic [1:0] d_out;
		logic [1:0] d_oe;
	} bir_link_t;

endpackage : bir_pkg

//--- bir_sync.sv
// two-stage synchroniser for levels entering a clock domain
// assumes input bits are independent levels
module bir_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} bir_sync_t;

	bir_sync_t st_q, st_d;

	// first stage feeds only the second
	always_comb begin
		st_d.s1 = din;
		st_d.s2 = st_q.s1;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign dout = st_q.s2;
endmodule : bir_sync

//--- bir_top.sv
// board interrupt routing: cascaded legacy controllers, 24-input
// message unit on a serial two-line bus, and error interrupt
// assumes pins are asynchronous; cpu_ack, eoi and config are on sys_clk
//
// Behaviour
// - two cascaded controllers; secondary levels 8-15 enter primary level 2
// - compatibility mode drives one cpu line; one processor services each
// - each pci interrupt can be steered onto legacy level 1 or 3 to 15
// - steered pci requests never appear on message unit inputs 0 to 15
// - message unit watches inputs and sends a message per request
// - message bus is one clock and two shared two-way data lines
// - the message unit has 24 request inputs
// - legacy levels 0 to 15 feed message inputs 0 to 15
// - pci lines a to d feed message inputs 16 to 19
// - one redirection entry per input shapes its message
// - error sources such as pci parity combine into system mgmt interrupt
`include "bir_params.svh"
module bir_top (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic apic_clk,
	input wire logic apic_mode,
	input wire logic [15:0] isa_irq,
	input wire logic rtc_irq_n,
	input wire logic pci_irq_a_n,
	input wire logic pci_irq_b_n,
	input wire logic pci_irq_c_n,
	input wire logic pci_irq_d_n,
	input wire logic [3:0] spare_irq,
	input wire logic pci_perr_n,
	input wire logic pci_serr_n,
	input wire logic ext_err,
	input wire logic [2:0] smi_en,
	input wire logic [15:0] pci_route,
	input wire logic [15:0] pic_mask,
	input wire logic [1:0] cpu_ack,
	input wire logic cpu_eoi,
	input wire logic [3:0] eoi_level,
	input wire logic [191:0] redir_vec,
	input wire logic [23:0] redir_level,
	input wire logic [23:0] redir_low,
	input wire logic [23:0] redir_mask,
	input wire logic apic_eoi,
	input wire logic [4:0] apic_eoi_idx,
	input wire logic [1:0] apic_d_in,
	output logic [1:0] apic_d_out,
	output logic [1:0] apic_d_oe,
	output logic cpu_irq_line,
	output logic ack_valid,
	output logic [3:0] ack_level,
	output logic [1:0] ack_owner,
	output logic sys_mgmt_int_n
);
	bir_pkg::bir_sys_t s_q, s_d;
	bir_pkg::bir_link_t l_q, l_d;

	logic [`BIR_PIN_W-1:0] pin_s;
	logic [15:0] isa_s;
	logic [3:0] pci_n_s;
	logic [3:0] spare_s;
	logic [2:0] err_s;
	logic ack_s;
	logic [2:0] lk_s;
	logic [15:0] lvl;
	logic [15:0] shared;
	logic [23:0] ain;
	logic [23:0] act;
	logic [23:0] elig;
	logic [4:0] pick;
	logic picked;
	logic busy;
	logic load;
	logic pri_int;
	logic sec_int;
	logic [2:0] pri_sel;
	logic [2:0] sec_sel;
	logic take;
	logic [23:0] rirr_clr;

	bir_sync #(.W(`BIR_PIN_W)) u_pin_sync (
		.clk(sys_clk),
		.rst_n(reset_n),
		.din({ext_err, ~pci_serr_n, ~pci_perr_n, spare_irq,
			pci_irq_d_n, pci_irq_c_n, pci_irq_b_n, pci_irq_a_n,
			isa_irq[15:9], ~rtc_irq_n, isa_irq[7:0]}),
		.dout(pin_s)
	);

	assign isa_s = pin_s[15:0];
	assign pci_n_s = pin_s[19:16];
	assign spare_s = pin_s[23:20];
	assign err_s = pin_s[26:24];

	bir_sync #(.W(1)) u_ack_sync (
		.clk(sys_clk),
		.rst_n(reset_n),
		.din(l_q.ack_tgl),
		.dout(ack_s)
	);

	always_comb begin
		lvl = isa_s;
		shared = 16'h0000;
		for (int p = 0; p < `BIR_NUM_PCI; p++) begin
			if (pci_route[4*p +: 4] != 4'h0) begin
				shared[pci_route[4*p +: 4]] = 1'b1;
				if (!pci_n_s[p]) begin
					lvl[pci_route[4*p +: 4]] = 1'b1;
				end
			end
		end
	end

	bir_pic u_sec (
		.clk(sys_clk),
		.rst_n(reset_n),
		.req(lvl[15:8]),
		// edge unless a pci line is shared on it
		.edge_mode(~shared[15:8]),
		.mask(pic_mask[15:8]),
		.ack(take && pri_sel == `BIR_CASC_LVL),
		.eoi(cpu_eoi && eoi_level[3]),
		.eoi_lvl(eoi_level[2:0]),
		.int_o(sec_int),
		.sel(sec_sel)
	);

	bir_pic u_pri (
		.clk(sys_clk),
		.rst_n(reset_n),
		.req({lvl[7:3], sec_int, lvl[1:0]}),
		.edge_mode({~shared[7:3], 1'b0, ~shared[1:0]}),
		.mask(pic_mask[7:0]),
		.ack(take),
		// cascade level is released with any secondary eoi
		.eoi(cpu_eoi),
		.eoi_lvl(eoi_level[3] ? `BIR_CASC_LVL : eoi_level[2:0]),
		.int_o(pri_int),
		.sel(pri_sel)
	);

	assign take = !apic_mode && pri_int && (cpu_ack != 2'h0);

	// steering stays inside the legacy path
	assign ain = {spare_s, pci_n_s, isa_s};
	assign act = ain ^ redir_low;
	assign busy = s_q.req_tgl ^ ack_s;
	assign elig = s_q.pend & ~redir_mask;

	always_comb begin
		pick = 5'h00;
		picked = 1'b0;
		for (int i = `BIR_NUM_IN - 1; i >= 0; i--) begin
			if (elig[i]) begin
				pick = 5'(i);
				picked = 1'b1;
			end
		end
	end

	// launch message when bus path free
	assign load = apic_mode && !busy && picked;
	assign rirr_clr = apic_eoi ? (24'h000001 << apic_eoi_idx) : 24'h000000;

	always_comb begin
		s_d = s_q;
		s_d.prev = act;
		s_d.ack_valid = take;
		s_d.rirr = s_q.rirr & ~rirr_clr;
		if (load) begin
			s_d.pend[pick] = 1'b0;
			s_d.rirr[pick] = redir_level[pick];
			s_d.req_tgl = ~s_q.req_tgl;
			// entry vector and trigger in the message
			s_d.msg = {redir_vec[8*pick +: 8], pick, redir_level[pick]};
		end
		// level entries wait for eoi, edge entries fire once
		// a fresh request beats the send clear of the same cycle
		s_d.pend = s_d.pend | (redir_level & act & ~s_d.rirr)
			| (~redir_level & act & ~s_q.prev);
		// compatibility-mode events must not leak into message mode
		if (!apic_mode) begin
			s_d.pend = 24'h000000;
		end
		if (take) begin
			s_d.ack_owner = cpu_ack[0] ? 2'h1 : 2'h2;
			s_d.ack_level = (pri_sel == `BIR_CASC_LVL) ?
				{1'b1, sec_sel} : {1'b0, pri_sel};
		end
		s_d.cpu_irq = pri_int && !apic_mode;
		// enabled error sources raise the interrupt
		s_d.smi_n = !(|(err_s & smi_en));
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			s_q <= '0;
			s_q.smi_n <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign cpu_irq_line = s_q.cpu_irq;
	assign ack_valid = s_q.ack_valid;
	assign ack_level = s_q.ack_level;
	assign ack_owner = s_q.ack_owner;
	assign sys_mgmt_int_n = s_q.smi_n;

	// link side: request toggle and both data lines enter apic_clk
	bir_sync #(.W(3)) u_link_sync (
		.clk(apic_clk),
		.rst_n(reset_n),
		.din({s_q.req_tgl, apic_d_in}),
		.dout(lk_s)
	);

	always_comb begin
		l_d = l_q;
		l_d.d_out = 2'h0;
		unique case (l_q.st)
			bir_pkg::BIR_L_IDLE: begin
				// msg is held steady in sys_clk until the ack toggles
				if (lk_s[2] != l_q.seen) begin
					l_d.sh = s_q.msg;
					l_d.st = bir_pkg::BIR_L_WAIT;
				end
			end
			bir_pkg::BIR_L_WAIT: begin
				// no arbitration: waits for both lines released
				if (lk_s[1:0] == 2'h3) begin
					l_d.st = bir_pkg::BIR_L_START;
					l_d.d_oe = `BIR_OE_START;
				end
			end
			bir_pkg::BIR_L_START: begin
				l_d.st = bir_pkg::BIR_L_DATA;
				l_d.cnt = 3'h0;
				l_d.d_oe = ~l_q.sh[13:12];
				l_d.sh = {l_q.sh[11:0], 2'h0};
			end
			bir_pkg::BIR_L_DATA: begin
				if (l_q.cnt == `BIR_MSG_CYC) begin
					l_d.st = bir_pkg::BIR_L_END;
					l_d.d_oe = `BIR_OE_IDLE;
				end else begin
					l_d.cnt = l_q.cnt + 3'h1;
					l_d.d_oe = ~l_q.sh[13:12];
					l_d.sh = {l_q.sh[11:0], 2'h0};
				end
			end
			bir_pkg::BIR_L_END: begin
				l_d.seen = ~l_q.seen;
				l_d.ack_tgl = ~l_q.ack_tgl;
				l_d.st = bir_pkg::BIR_L_IDLE;
			end
		endcase
	end

	always_ff @(posedge apic_clk or negedge reset_n) begin
		if (!reset_n) begin
			l_q <= '0;
		end else begin
			l_q <= l_d;
		end
	end

	assign apic_d_out = l_q.d_out;
	assign apic_d_oe = l_q.d_oe;

	a_irq_compat: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		$rose(cpu_irq_line) |-> $past(!apic_mode))
		else $error("cpu line raised in message mode");

	a_ack_single: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		ack_valid |-> $onehot(ack_owner) && $past(!apic_mode))
		else $error("acknowledge not owned by one processor");

	a_cascade_ack: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		(ack_valid && ack_level[3]) |-> $past(pri_sel) == 3'h2)
		else $error("secondary level acked without cascade");

	a_steer_nz: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		(pci_route[3:0] == 4'h0) |-> !shared[0])
		else $error("level 0 taken by steering");

	a_msg_mode: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		(s_q.req_tgl != $past(s_q.req_tgl)) |-> $past(apic_mode))
		else $error("message launched outside message mode");

	a_msg_entry: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		load |=> s_q.msg[5:1] == $past(pick)
			&& s_q.msg[13:6] == $past(redir_vec[8*pick +: 8]))
		else $error("message does not match its entry");

	a_level_hold: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		(load && redir_level[pick]) |=> s_q.rirr[$past(pick)])
		else $error("level entry not held after send");

	a_no_resend: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		busy |-> !load)
		else $error("second message while one is in flight");

	a_frame_len: assert property (
		@(posedge apic_clk) disable iff (!reset_n)
		(l_q.st == bir_pkg::BIR_L_START)
			|=> (l_q.st == bir_pkg::BIR_L_DATA) [*7]
			##1 (l_q.st == bir_pkg::BIR_L_END))
		else $error("message frame length wrong");

	a_start_low: assert property (
		@(posedge apic_clk) disable iff (!reset_n)
		(l_q.st == bir_pkg::BIR_L_START) |-> apic_d_oe == 2'h3
			&& apic_d_out == 2'h0)
		else $error("start cycle not both lines low");

	a_smi_cause: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		$fell(sys_mgmt_int_n) |-> $past(|(err_s & smi_en)))
		else $error("error interrupt without enabled source");

	c_frame: cover property (
		@(posedge apic_clk) disable iff (!reset_n)
		l_q.st == bir_pkg::BIR_L_END);

	c_casc_ack: cover property (
		@(posedge sys_clk) disable iff (!reset_n)
		ack_valid && ack_level[3]);

	c_pci_msg: cover property (
		@(posedge sys_clk) disable iff (!reset_n)
		load && pick == 5'h10);

	c_smi: cover property (
		@(posedge sys_clk) disable iff (!reset_n)
		!sys_mgmt_int_n);
endmodule : bir_top

//--- test_board_interrupt_routing.sv
// self-checking bench for the board interrupt routing block
// assumes bir_top and the far-end model are compiled before it
module test_board_interrupt_routing;
	timeunit 1ns;
	timeprecision 100ps;
	logic sys_clk = 0, apic_clk = 0, reset_n = 0, apic_mode = 0;
	logic [15:0] isa_irq = 16'h0, pci_route = 16'h0, pic_mask = 16'h0;
	logic rtc_irq_n = 1, perr_n = 1, serr_n = 1, ext_err = 0, hold = 0;
	logic [3:0] pci_n = 4'hf, spare_irq = 4'h0, eoi_level = 4'h0;
	logic [2:0] smi_en = 3'h0;
	logic [1:0] cpu_ack = 2'h0, d_in, d_out, d_oe, ack_owner;
	logic cpu_eoi = 0, apic_eoi = 0, cpu_irq_line, ack_valid, smi_n;
	logic [191:0] redir_vec = 192'h0;
	logic [23:0] redir_level = 24'h0, redir_low = 24'h0, redir_mask = 24'h0;
	logic [4:0] eoi_idx = 5'h0;
	logic [3:0] ack_level;
	logic [13:0] last_msg;
	logic [13:0] exp_q[$];
	int frames, bad_count = 0, checked = 0, k, n;
	bir_top dut_u (.sys_clk(sys_clk), .reset_n(reset_n),
		.apic_clk(apic_clk), .apic_mode(apic_mode), .isa_irq(isa_irq),
		.rtc_irq_n(rtc_irq_n), .pci_irq_a_n(pci_n[0]),
		.pci_irq_b_n(pci_n[1]), .pci_irq_c_n(pci_n[2]),
		.pci_irq_d_n(pci_n[3]), .spare_irq(spare_irq),
		.pci_perr_n(perr_n), .pci_serr_n(serr_n), .ext_err(ext_err),
		.smi_en(smi_en), .pci_route(pci_route), .pic_mask(pic_mask),
		.cpu_ack(cpu_ack), .cpu_eoi(cpu_eoi), .eoi_level(eoi_level),
		.redir_vec(redir_vec), .redir_level(redir_level),
		.redir_low(redir_low), .redir_mask(redir_mask),
		.apic_eoi(apic_eoi), .apic_eoi_idx(eoi_idx), .apic_d_in(d_in),
		.apic_d_out(d_out), .apic_d_oe(d_oe), .cpu_irq_line(cpu_irq_line),
		.ack_valid(ack_valid), .ack_level(ack_level),
		.ack_owner(ack_owner), .sys_mgmt_int_n(smi_n));
	bir_far_end far_u (.apic_clk(apic_clk), .reset_n(reset_n),
		.d_oe(d_oe), .hold(hold), .d_in(d_in), .last_msg(last_msg),
		.frames(frames));
	initial begin
		forever #10 sys_clk = ~sys_clk;
	end
	// link clock unrelated in phase to the system clock
	initial begin
		#7;
		forever #32 apic_clk = ~apic_clk;
	end
	task automatic check(string what, logic [13:0] seen, logic [13:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic cyc(int c);
		repeat (c) @(posedge sys_clk);
	endtask : cyc
	task automatic pin(int i, logic a);
		if (i == 8)
			rtc_irq_n <= ~a;
		else if (i < 16)
			isa_irq[i] <= a;
		else if (i < 20)
			pci_n[i-16] <= ~a;
		else
			spare_irq[i-20] <= a;
	endtask : pin
	task automatic serve(int l, int i);
		logic [1:0] a;
		a = 2'($urandom_range(1, 3));
		k = 0;
		while (cpu_irq_line !== 1'b1 && k < 30) begin
			@(posedge sys_clk);
			#1;
			k++;
		end
		check("cpu_irq_line", cpu_irq_line, 14'h1);
		@(posedge sys_clk);
		cpu_ack <= a;
		@(posedge sys_clk);
		cpu_ack <= 2'h0;
		pin(i, 0);
		#1;
		check("ack_valid", ack_valid, 14'h1);
		check("ack_level", ack_level, 14'(l));
		check("ack_owner", ack_owner, a == 2'h3 ? 14'h1 : 14'(a));
		@(posedge sys_clk);
		cpu_eoi <= 1;
		eoi_level <= 4'(l);
		@(posedge sys_clk);
		cpu_eoi <= 0;
		cyc(4);
	endtask : serve
	task automatic errpin(int s, logic a);
		if (s == 0)
			perr_n <= ~a;
		else if (s == 1)
			serr_n <= ~a;
		else
			ext_err <= a;
	endtask : errpin
	task automatic results;
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : results
	initial begin
		#300us;
		bad_count++;
		results;
	end
	initial begin
		void'($urandom(39332));
		cyc(8);
		reset_n <= 1;
		cyc(4);
		for (int l = 0; l < 16; l++)
			if (l != 2) begin
				pin(l, 1);
				serve(l, l);
			end
		$display("legacy levels done");
		for (int p = 0; p < 4; p++) begin
			@(posedge sys_clk);
			pci_route <= 16'(9 + p) << (4 * p);
			pin(16 + p, 1);
			// pci line steered onto legacy level
			serve(9 + p, 16 + p);
		end
		$display("pci steering done");
		@(posedge sys_clk);
		apic_mode <= 1;
		pci_route <= 16'h0009;
		redir_level <= 24'h0f0000;
		redir_low <= 24'h0f0000;
		for (int j = 0; j < 6; j++)
			redir_vec[32*j +: 32] <= $urandom;
		cyc(4);
		for (int i = 0; i < 24; i++) begin
			n = frames;
			exp_q.push_back({redir_vec[8*i +: 8], 5'(i), redir_level[i]});
			pin(i, 1);
			if (i == 5) begin
				hold <= 1;
				cyc(60);
				check("stalled", 14'(frames - n), 14'h0);
				hold <= 0;
			end
			k = 0;
			while (frames == n && k < 400) begin
				@(posedge sys_clk);
				k++;
			end
			check("message", last_msg, exp_q.pop_front());
			check("d_out", d_out, 14'h0);
			pin(i, 0);
			// a level input must clear the synchroniser before eoi
			cyc(3);
			apic_eoi <= 1;
			eoi_idx <= 5'(i);
			@(posedge sys_clk);
			apic_eoi <= 0;
			cyc(8);
		end
		$display("message inputs done");
		for (int s = 0; s < 3; s++) begin
			@(posedge sys_clk);
			smi_en <= ~(3'h1 << s);
			errpin(s, 1);
			cyc(6);
			#1;
			check("smi disabled", smi_n, 14'h1);
			@(posedge sys_clk);
			smi_en <= 3'h7;
			cyc(4);
			#1;
			check("smi raised", smi_n, 14'h0);
			@(posedge sys_clk);
			errpin(s, 0);
			cyc(6);
			#1;
			check("smi cleared", smi_n, 14'h1);
		end
		$display("error sources done");
		results;
	end
endmodule : test_board_interrupt_routing
